// ===== common/osp_pkg.sv
// constants, register map and carrier types of the one-shot pulse timer
package osp_pkg;
  // timing of the system clock and the documented limits
  localparam int unsigned CLK_PERIOD_PS = 50000;
  localparam int unsigned MIN_DELAY_US = 1;
  localparam int unsigned MIN_DELAY_PS = MIN_DELAY_US * 1000000;
  localparam int unsigned MIN_DELAY_CYC =
    (MIN_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned MIN_WIDTH_PS = 50860;
  localparam int unsigned MIN_WIDTH_CYC =
    (MIN_WIDTH_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned MEM_DEPTH = 4;

  // register indices on the plain register port
  localparam logic [7:0] OFS_COUNTER_RUN = 8'h00;
  localparam logic [7:0] OFS_TIMER_MODE = 8'h01;
  localparam logic [7:0] OFS_IO_CONTROL = 8'h02;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h03;
  localparam logic [7:0] OFS_TIMER_FLAG = 8'h04;
  localparam logic [7:0] OFS_CHAN_COUNTER = 8'h05;
  localparam logic [7:0] OFS_CAPTURE_A = 8'h06;
  localparam logic [7:0] OFS_DELAY_CMP = 8'h07;
  localparam logic [7:0] OFS_DISABLE_CMP = 8'h08;
  localparam logic [7:0] OFS_RESET_BUF = 8'h09;
  localparam logic [7:0] OFS_DMA_CTRL = 8'h0a;
  localparam logic [7:0] OFS_DMA_A_SRC = 8'h0b;
  localparam logic [7:0] OFS_DMA_A_DST = 8'h0c;
  localparam logic [7:0] OFS_DMA_A_CNT = 8'h0d;
  localparam logic [7:0] OFS_DMA_B_SRC = 8'h0e;
  localparam logic [7:0] OFS_DMA_B_DST = 8'h0f;
  localparam logic [7:0] OFS_DMA_B_CNT = 8'h10;
  localparam logic [7:0] OFS_PIN_STATUS = 8'h11;
  localparam logic [7:0] OFS_DATA_MEM = 8'h20;

  // field positions
  localparam int unsigned MODE_BUF_BD = 0;
  localparam int unsigned MODE_CLR_CAP = 1;
  localparam int unsigned IOA_CAPTURE = 3;
  localparam int unsigned IOB_CAPTURE = 7;
  localparam int unsigned IEN_DMA_START = 0;
  localparam int unsigned FLAG_A = 0;
  localparam int unsigned FLAG_B = 1;
  localparam int unsigned FLAG_C = 2;
  localparam int unsigned DCTL_A_EN = 0;
  localparam int unsigned DCTL_B_EN = 1;
  localparam int unsigned DCTL_A_RPT = 2;
  localparam int unsigned DCTL_B_RPT = 3;

  // reset values and the enabled io control byte
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] RST_COMPARE = 16'hffff;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] IO_CTRL_ENABLED = 8'h39;

  // capture edge and compare output actions
  typedef enum logic [1:0] {
    EDGE_RISE, EDGE_FALL, EDGE_BOTH, EDGE_BOTH_ALT
  } osp_edge_type;
  typedef enum logic [2:0] {
    OUT_OFF, OUT_LOW, OUT_HIGH, OUT_TOGGLE,
    OUT_RSV4, OUT_RSV5, OUT_RSV6, OUT_RSV7
  } osp_out_type;

  // internal register write port shared by bus and dma
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [15:0] data;
  } osp_wr_type;

  // one dma channel setting
  typedef struct packed {
    logic [15:0] src;
    logic [15:0] dst;
    logic [15:0] cnt;
  } osp_dma_type;
endpackage

// ===== hw/osp_timer.sv
// one-shot pulse timer channel with capture-started dma reload
//
// Function
// - one pulse per falling trigger edge
// - buffer copied into compare on match
// - general registers A and B capture or compare selectable
// - capture A clears counter when selected
// - capture A event starts dma transfers
// - delay equals count times clock period
// - reset instant counted from capture clear
// - control byte: falling capture, toggle B
// - io control sets pin on match B
// - compare C marks disable, raises irq
// - flag set on delay compare match
// - run bit gates counter advance
// - dma holds source, destination, count
// - dma A word moves delay to B
// - dma B byte moves control byte
// - capture clears; B and D buffered
//
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/100ps
module osp_timer import osp_pkg::*; #(
  parameter int unsigned MEM_N = MEM_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // pins
  input wire logic trigger_in_pin,
  output logic pulse_out_pin,
  output logic pulse_out_oe,
  // compare C request
  output logic compare_c_irq
);
  logic run_q;
  logic [7:0] mode_q;
  logic [7:0] ioc_q;
  logic [7:0] ien_q;
  logic [2:0] flag_q;
  logic [15:0] cnt_q;
  logic [15:0] gra_q, grb_q, grc_q, grd_q;
  logic [3:0] dctl_q;
  osp_dma_type dma_a_q, dma_b_q, cur_a_q, cur_b_q;
  logic [15:0] mem_q [MEM_N];
  logic [1:0] pend_q;
  logic trig_s1_q, trig_s2_q, trig_s3_q;
  logic pin_q, oe_q, irq_q;
  logic [15:0] rdata_q;
  osp_wr_type wr;
  logic xfer_a, xfer_b;
  logic edge_evt, cap_a, cap_b, hit_a, hit_b, hit_c;
  osp_out_type act_b;

  function automatic logic wr_hit(input osp_wr_type w,
                                  input logic [7:0] ofs);
    wr_hit = w.en && (w.addr == ofs);
  endfunction

  function automatic logic [15:0] mem_word(input logic [15:0] idx);
    mem_word = mem_q[idx[$clog2(MEM_N)-1:0]];
  endfunction

  // trigger synchroniser; stage one feeds only stage two
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trig_s1_q <= 1'b1;
      trig_s2_q <= 1'b1;
      trig_s3_q <= 1'b1;
    end else begin
      trig_s1_q <= trigger_in_pin;
      trig_s2_q <= trig_s1_q;
      trig_s3_q <= trig_s2_q;
    end
  end

  always_comb begin
    unique case (osp_edge_type'(ioc_q[1:0]))
      EDGE_RISE: edge_evt = trig_s2_q & ~trig_s3_q;
      EDGE_FALL: edge_evt = ~trig_s2_q & trig_s3_q;
      EDGE_BOTH, EDGE_BOTH_ALT: edge_evt = trig_s2_q ^ trig_s3_q;
    endcase
  end

  // capture only while counting, so a stopped channel ignores the pin
  assign cap_a = run_q & ioc_q[IOA_CAPTURE] & edge_evt;
  assign cap_b = run_q & ioc_q[IOB_CAPTURE] & edge_evt;
  assign hit_a = run_q & ~ioc_q[IOA_CAPTURE] & (cnt_q == gra_q);
  assign hit_b = run_q & ~ioc_q[IOB_CAPTURE] & (cnt_q == grb_q);
  assign hit_c = run_q & (cnt_q == grc_q);
  assign act_b = osp_out_type'(ioc_q[6:4]);

  // write port: bus first, then dma A, then dma B
  always_comb begin
    wr = '0;
    xfer_a = 1'b0;
    xfer_b = 1'b0;
    if (reg_wr) begin
      wr = '{en: 1'b1, addr: reg_addr, data: reg_wdata};
    end else if (pend_q[0]) begin
      xfer_a = 1'b1;
      wr = '{en: 1'b1, addr: cur_a_q.dst[7:0],
             data: mem_word(cur_a_q.src)};
    end else if (pend_q[1]) begin
      xfer_b = 1'b1;
      wr = '{en: 1'b1, addr: cur_b_q.dst[7:0],
             data: {8'h00, 8'(mem_word(cur_b_q.src))}};
    end
  end

  // control registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_q <= 1'b0;
      mode_q <= RST_BYTE;
      ioc_q <= RST_BYTE;
      ien_q <= RST_BYTE;
    end else begin
      if (wr_hit(wr, OFS_COUNTER_RUN)) run_q <= wr.data[0];
      if (wr_hit(wr, OFS_TIMER_MODE)) mode_q <= wr.data[7:0];
      if (wr_hit(wr, OFS_IO_CONTROL)) ioc_q <= wr.data[7:0];
      if (wr_hit(wr, OFS_IRQ_ENABLE)) ien_q <= wr.data[7:0];
    end
  end

  // counter: capture clear beats software write beats advance
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= RST_WORD;
    end else if (cap_a && mode_q[MODE_CLR_CAP]) begin
      cnt_q <= RST_WORD;
    end else if (wr_hit(wr, OFS_CHAN_COUNTER)) begin
      cnt_q <= wr.data;
    end else if (run_q) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // general registers; hardware events win over writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gra_q <= RST_COMPARE;
      grb_q <= RST_COMPARE;
      grc_q <= RST_COMPARE;
      grd_q <= RST_COMPARE;
    end else begin
      if (cap_a) gra_q <= cnt_q;
      else if (wr_hit(wr, OFS_CAPTURE_A)) gra_q <= wr.data;
      if (cap_b) grb_q <= cnt_q;
      else if (hit_b && mode_q[MODE_BUF_BD]) grb_q <= grd_q;
      else if (wr_hit(wr, OFS_DELAY_CMP)) grb_q <= wr.data;
      if (wr_hit(wr, OFS_DISABLE_CMP)) grc_q <= wr.data;
      if (wr_hit(wr, OFS_RESET_BUF)) grd_q <= wr.data;
    end
  end

  // sticky flags, write one to clear, a new event wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_q <= 3'h0;
    end else begin
      flag_q <= (flag_q & ~({3{wr_hit(wr, OFS_TIMER_FLAG)}} & wr.data[2:0]))
        | {hit_c, hit_b, cap_a | hit_a};
    end
  end

  // dma channel settings and enable bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dctl_q <= 4'h0;
      dma_a_q <= '0;
      dma_b_q <= '0;
    end else begin
      if (wr_hit(wr, OFS_DMA_CTRL)) dctl_q <= wr.data[3:0];
      else begin
        if (xfer_a && cur_a_q.cnt == 16'h0001 && !dctl_q[DCTL_A_RPT])
          dctl_q[DCTL_A_EN] <= 1'b0;
        if (xfer_b && cur_b_q.cnt == 16'h0001 && !dctl_q[DCTL_B_RPT])
          dctl_q[DCTL_B_EN] <= 1'b0;
      end
      if (wr_hit(wr, OFS_DMA_A_SRC)) dma_a_q.src <= wr.data;
      if (wr_hit(wr, OFS_DMA_A_DST)) dma_a_q.dst <= wr.data;
      if (wr_hit(wr, OFS_DMA_A_CNT)) dma_a_q.cnt <= wr.data;
      if (wr_hit(wr, OFS_DMA_B_SRC)) dma_b_q.src <= wr.data;
      if (wr_hit(wr, OFS_DMA_B_DST)) dma_b_q.dst <= wr.data;
      if (wr_hit(wr, OFS_DMA_B_CNT)) dma_b_q.cnt <= wr.data;
    end
  end

  // working address and count; last transfer reloads the set values
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur_a_q <= '0;
      cur_b_q <= '0;
    end else begin
      if (wr_hit(wr, OFS_DMA_CTRL)) begin
        cur_a_q <= dma_a_q;
        cur_b_q <= dma_b_q;
      end else begin
        if (xfer_a) begin
          if (cur_a_q.cnt == 16'h0001) cur_a_q <= dma_a_q;
          else begin
            cur_a_q.src <= cur_a_q.src + 16'h0001;
            cur_a_q.cnt <= cur_a_q.cnt - 16'h0001;
          end
        end
        if (xfer_b) begin
          if (cur_b_q.cnt == 16'h0001) cur_b_q <= dma_b_q;
          else begin
            cur_b_q.src <= cur_b_q.src + 16'h0001;
            cur_b_q.cnt <= cur_b_q.cnt - 16'h0001;
          end
        end
      end
    end
  end

  // pending requests from capture A; a new request wins over done
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_q <= 2'b00;
    end else begin
      pend_q[0] <= (pend_q[0] & ~xfer_a) | (cap_a & ien_q[IEN_DMA_START]
        & dctl_q[DCTL_A_EN]);
      pend_q[1] <= (pend_q[1] & ~xfer_b) | (cap_a & ien_q[IEN_DMA_START]
        & dctl_q[DCTL_B_EN]);
    end
  end

  // data words the dma channels read from
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < MEM_N; i++) mem_q[i] <= RST_WORD;
    end else begin
      for (int i = 0; i < MEM_N; i++)
        if (wr_hit(wr, OFS_DATA_MEM + 8'(i))) mem_q[i] <= wr.data;
    end
  end

  // pulse pin; toggling on B twice frames delay and width
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      oe_q <= !ioc_q[IOB_CAPTURE] && act_b != OUT_OFF;
      if (hit_b) begin
        unique case (act_b)
          OUT_OFF: pin_q <= 1'b0;
          OUT_LOW: pin_q <= 1'b0;
          OUT_HIGH: pin_q <= 1'b1;
          OUT_TOGGLE: pin_q <= ~pin_q;
          default: pin_q <= pin_q;
        endcase
      end else if (act_b == OUT_OFF) begin
        pin_q <= 1'b0;
      end
    end
  end

  // request line follows the enabled flags
  always_ff @(posedge clk or posedge rst) begin
    if (rst) irq_q <= 1'b0;
    else irq_q <= |(flag_q & ien_q[3:1]);
  end

  // read data stand for one cycle only; unmapped reads zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= RST_WORD;
    end else if (!reg_rd) begin
      rdata_q <= RST_WORD;
    end else begin
      rdata_q <= RST_WORD;
      unique case (reg_addr)
        OFS_COUNTER_RUN: rdata_q <= {15'h0000, run_q};
        OFS_TIMER_MODE: rdata_q <= {8'h00, mode_q};
        OFS_IO_CONTROL: rdata_q <= {8'h00, ioc_q};
        OFS_IRQ_ENABLE: rdata_q <= {8'h00, ien_q};
        OFS_TIMER_FLAG: rdata_q <= {13'h0000, flag_q};
        OFS_CHAN_COUNTER: rdata_q <= cnt_q;
        OFS_CAPTURE_A: rdata_q <= gra_q;
        OFS_DELAY_CMP: rdata_q <= grb_q;
        OFS_DISABLE_CMP: rdata_q <= grc_q;
        OFS_RESET_BUF: rdata_q <= grd_q;
        OFS_DMA_CTRL: rdata_q <= {12'h000, dctl_q};
        OFS_DMA_A_SRC: rdata_q <= dma_a_q.src;
        OFS_DMA_A_DST: rdata_q <= dma_a_q.dst;
        OFS_DMA_A_CNT: rdata_q <= dma_a_q.cnt;
        OFS_DMA_B_SRC: rdata_q <= dma_b_q.src;
        OFS_DMA_B_DST: rdata_q <= dma_b_q.dst;
        OFS_DMA_B_CNT: rdata_q <= dma_b_q.cnt;
        OFS_PIN_STATUS: rdata_q <= {13'h0000, pend_q != 2'b00,
                                    trig_s2_q, pin_q};
        default: begin
          for (int i = 0; i < MEM_N; i++)
            if (reg_addr == OFS_DATA_MEM + 8'(i)) rdata_q <= mem_q[i];
        end
      endcase
    end
  end

  assign reg_rdata = rdata_q;
  assign pulse_out_pin = pin_q;
  assign pulse_out_oe = oe_q;
  assign compare_c_irq = irq_q;
endmodule // osp_timer

// ===== bench/osp_properties.sv
// port-level checks of the one-shot pulse timer
`timescale 1ns/100ps
module osp_properties import osp_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  // pins
  input wire logic trigger_in_pin,
  input wire logic pulse_out_pin,
  input wire logic pulse_out_oe,
  input wire logic compare_c_irq
);
  logic [15:0] dly_q, end_q, dis_q, since_q, hi_q, idle_q;
  logic run_q, armed_q, trig_q, pin_q;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // settings snooped from bus writes; dma copies are not seen here
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dly_q <= RST_WORD;
      end_q <= RST_COMPARE;
      dis_q <= RST_COMPARE;
      run_q <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == OFS_DATA_MEM) dly_q <= reg_wdata;
      if (reg_addr == OFS_RESET_BUF) end_q <= reg_wdata;
      if (reg_addr == OFS_DISABLE_CMP) dis_q <= reg_wdata;
      if (reg_addr == OFS_COUNTER_RUN) run_q <= reg_wdata[0];
    end
  end
  // cycles since trigger fall, pulse rise and run stop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trig_q <= 1'b1;
      pin_q <= 1'b0;
      since_q <= RST_WORD;
      hi_q <= RST_WORD;
      idle_q <= RST_WORD;
      armed_q <= 1'b0;
    end else begin
      trig_q <= trigger_in_pin;
      pin_q <= pulse_out_pin;
      since_q <= (trig_q && !trigger_in_pin) ? 16'h0001 : since_q + 16'h0001;
      hi_q <= (pulse_out_pin && !pin_q) ? 16'h0001 : hi_q + 16'h0001;
      idle_q <= run_q ? 16'h0000 : idle_q + {15'h0000, ~&idle_q};
      if (trig_q && !trigger_in_pin) armed_q <= 1'b1;
      else if (pulse_out_pin && !pin_q) armed_q <= 1'b0;
    end
  end
  sequence s_io_wr;
    reg_wr && reg_addr == OFS_IO_CONTROL;
  endsequence
  sequence s_rise;
    $rose(pulse_out_pin);
  endsequence
  property p_single;
    s_rise |-> armed_q;
  endproperty
  property p_delay;
    s_rise |-> since_q >= dly_q + 16'd2 && since_q <= dly_q + 16'd6;
  endproperty
  property p_width;
    $fell(pulse_out_pin) |-> hi_q == end_q - dly_q;
  endproperty
  property p_irq_at;
    $rose(compare_c_irq) |-> since_q >= dis_q + 16'd3 &&
      since_q <= dis_q + 16'd7;
  endproperty
  property p_irq_hold;
    $fell(compare_c_irq) |-> $past(reg_wr, 2);
  endproperty
  property p_run_hold;
    idle_q > 16'd3 |-> $stable(pulse_out_pin);
  endproperty
  property p_oe;
    logic [15:0] v;
    (s_io_wr, v = reg_wdata) |-> ##2
      pulse_out_oe == (v[6:4] != 3'h0 && !v[7]);
  endproperty
  property p_rd_idle;
    !reg_rd |=> reg_rdata == 16'h0000;
  endproperty
  a_single: assert property (p_single)
    else $error("pulse rose without a fresh trigger fall");
  a_delay: assert property (p_delay)
    else $error("pulse rise off the programmed delay");
  a_width: assert property (p_width)
    else $error("pulse width differs from reset minus delay");
  a_irq_at: assert property (p_irq_at)
    else $error("compare c request at the wrong cycle");
  a_irq_hold: assert property (p_irq_hold)
    else $error("compare c request dropped without a write");
  a_run_hold: assert property (p_run_hold)
    else $error("pulse moved while the counter is halted");
  a_oe: assert property (p_oe)
    else $error("output enable does not follow io control");
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero outside the read answer");
endmodule // osp_properties

// ===== bench/osp_trig_src.sv
// trigger source and pulse monitor at the far side of the timer pins
`timescale 1ns/100ps
module osp_trig_src (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // one-cycle command from the bench
  input wire logic fire,
  // pins
  output logic trig,
  input wire logic pulse,
  // edges seen, in cycles after the trigger fall
  output logic [15:0] rise_at,
  output logic [15:0] fall_at
);
  logic [15:0] age_q;
  logic pulse_q;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      trig <= 1'b1;
      age_q <= 16'h0000;
      pulse_q <= 1'b0;
      rise_at <= 16'h0000;
      fall_at <= 16'h0000;
    end else begin
      age_q <= fire ? 16'h0000 : age_q + 16'h0001;
      // low well past the two-flop sync depth, idles high
      if (fire) trig <= 1'b0;
      else if (age_q == 16'h0003) trig <= 1'b1;
      pulse_q <= pulse;
      if (pulse && !pulse_q) rise_at <= age_q;
      if (!pulse && pulse_q) fall_at <= age_q;
    end
  end
endmodule // osp_trig_src

// ===== bench/testbench.sv
// self-checking bench of the one-shot pulse timer
`timescale 1ns/100ps
module testbench import osp_pkg::*;;
  logic clk, rst, reg_wr, reg_rd, fire, trig, pulse, oe, irq;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rise_at, fall_at, rd_v, dly, wid;
  int fail_count, comparisons;
  integer seed;
  localparam logic [7:0] RA [6] = '{OFS_COUNTER_RUN, OFS_IO_CONTROL,
    OFS_DELAY_CMP, OFS_DISABLE_CMP, OFS_RESET_BUF, 8'h15};
  localparam logic [15:0] RE [6] = '{16'h0000, 16'h0000, RST_COMPARE,
    RST_COMPARE, RST_COMPARE, 16'h0000};
  localparam logic [7:0] SA [12] = '{OFS_DATA_MEM + 8'h01, OFS_DMA_A_SRC,
    OFS_DMA_A_DST, OFS_DMA_A_CNT, OFS_DMA_B_SRC, OFS_DMA_B_DST,
    OFS_DMA_B_CNT, OFS_DMA_CTRL, OFS_IRQ_ENABLE, OFS_TIMER_MODE,
    OFS_IO_CONTROL, OFS_COUNTER_RUN};
  localparam logic [15:0] SD [12] = '{{8'h00, IO_CTRL_ENABLED}, 16'h0000,
    {8'h00, OFS_DELAY_CMP}, 16'h0001, 16'h0001, {8'h00, OFS_IO_CONTROL},
    16'h0001, 16'h000f, 16'h0009, 16'h0003, {8'h00, IO_CTRL_ENABLED},
    16'h0001};
  osp_timer DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .trigger_in_pin(trig), .pulse_out_pin(pulse),
    .pulse_out_oe(oe), .compare_c_irq(irq));
  osp_trig_src partner (.clk(clk), .rst(rst), .fire(fire), .trig(trig),
    .pulse(pulse), .rise_at(rise_at), .fall_at(fall_at));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // answer stands one cycle only, so sample mid-cycle
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask
  // compare c goes in after the capture so it cannot match early
  task automatic shoot(input logic [15:0] c);
    @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (8) @(posedge clk);
    wr(OFS_DISABLE_CMP, c);
    repeat (c + 16'd20) @(posedge clk);
  endtask
  // two sync cycles, the clear, then one cycle after the match
  function automatic logic [15:0] exp_rise(input logic [15:0] d);
    exp_rise = d + 16'd4;
  endfunction
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    end_of_test();
  end
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    fire = 1'b0;
    seed = 40;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd(RA[i], rd_v);
      chk(rd_v, RE[i]);
    end
    $display("reset values done");
    for (int i = 0; i < 12; i++) wr(SA[i], SD[i]);
    chk({15'h0000, oe}, 16'h0001);
    for (int i = 0; i < 6; i++) begin
      dly = 16'(MIN_DELAY_CYC) + 16'($unsigned($random(seed)) % 200);
      wid = 16'(MIN_WIDTH_CYC) + 16'($unsigned($random(seed)) % 40);
      if (i == 0) dly = 16'(MIN_DELAY_CYC);
      if (i == 0) wid = 16'(MIN_WIDTH_CYC);
      wr(OFS_DATA_MEM, dly);
      wr(OFS_RESET_BUF, dly + wid);
      wr(OFS_IO_CONTROL, 16'h0009);
      wr(OFS_TIMER_FLAG, 16'h0007);
      shoot(dly + wid + 16'd10);
      chk({15'h0000, (rise_at - dly) inside {[3:6]}}, 16'h0001);
      chk(rise_at, exp_rise(dly));
      chk(fall_at - rise_at, wid);
      chk({15'h0000, irq}, 16'h0001);
      rd(OFS_TIMER_FLAG, rd_v);
      chk(rd_v, 16'h0007);
      rd(OFS_IO_CONTROL, rd_v);
      chk(rd_v, {8'h00, IO_CTRL_ENABLED});
    end
    rd(OFS_DMA_A_CNT, rd_v);
    chk(rd_v, 16'h0001);
    // repeat channels keep their enables after every reload
    rd(OFS_DMA_CTRL, rd_v);
    chk(rd_v, 16'h000f);
    wr(OFS_TIMER_FLAG, 16'h0007);
    repeat (2) @(posedge clk);
    chk({15'h0000, irq}, 16'h0000);
    $display("pulse series done");
    wr(OFS_COUNTER_RUN, 16'h0000);
    shoot(16'h0040);
    chk({15'h0000, pulse}, 16'h0000);
    rd(OFS_TIMER_FLAG, rd_v);
    chk(rd_v, 16'h0000);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(OFS_DELAY_CMP, rd_v);
    chk(rd_v, RST_COMPARE);
    chk({15'h0000, oe}, 16'h0000);
    $display("halt and reset done");
    end_of_test();
  end
endmodule // testbench
bind osp_timer osp_properties u_props (.clk(clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .trigger_in_pin(trigger_in_pin), .pulse_out_pin(pulse_out_pin),
  .pulse_out_oe(pulse_out_oe), .compare_c_irq(compare_c_irq));
